//--- rtl/ucw_defines.svh
`ifndef UCW_DEFINES_SVH
`define UCW_DEFINES_SVH
`define UCW_RST_HALTED   1'b1
`define UCW_RST_ARMED    1'b1
`define UCW_RST_PENDING  1'b0
`define UCW_RST_UPGRADE  1'b0
`define UCW_RST_SEEN     1'b0
`define UCW_RST_PULSE    1'b0
`endif

//--- rtl/ucw_pkg.sv
package ucw_pkg;
  // decoded interprocessor message kind
  typedef enum logic [1:0] {
    UCW_MSG_NONE,
    UCW_MSG_INIT,
    UCW_MSG_WAKE
  } ucw_msg_t;
endpackage

//--- rtl/ucw_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser plus rising edge detect on the second stage
module ucw_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // async level in, clean pulse out
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta;   // first stage, read only by second stage
  logic stable; // second stage
  logic prev;   // delayed copy for edge detect

  // sample chain
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= async_in;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign rise_pulse = stable & ~prev;
endmodule

//--- rtl/ucw_wakeup_gate.sv
`timescale 1ns/10ps
`include "ucw_defines.svh"
// wake-up gate for a secondary processor core
module ucw_wakeup_gate
  import ucw_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // configuration strap, pin level
  input  wire logic upgrade_mode_pin,
  // soft init pin, asynchronous
  input  wire logic init_pin,
  // decoded message strobe, same clock
  input  wire logic msg_valid,
  input  wire logic msg_is_init,
  input  wire logic msg_is_wakeup,
  // status to the core
  output logic      halted,
  output logic      wake_armed,
  output logic      init_pending,
  output logic      upgrade_mode,
  output logic      fetch_enable,
  output logic      core_init_pulse
);
  logic     mode_meta;     // strap first stage
  logic     mode_sync;     // strap second stage
  logic     rst_seen;      // strap capture done
  logic     init_pin_rise; // synchronised pin edge
  logic     soft_init;     // init from either source
  ucw_msg_t msg_kind;      // decoded message
  logic     take_wake;     // accepted wakeup

  // pin edge synchroniser
  ucw_sync u_init_sync (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .async_in   (init_pin),
    .rise_pulse (init_pin_rise)
  );

  // classify message; init takes priority if both flagged
  always_comb begin
    if (!msg_valid)         msg_kind = UCW_MSG_NONE;
    else if (msg_is_init)   msg_kind = UCW_MSG_INIT;
    else if (msg_is_wakeup) msg_kind = UCW_MSG_WAKE;
    else                    msg_kind = UCW_MSG_NONE;
  end

  // strap synchroniser, plain chain with no reset
  // it keeps sampling through reset so the strap is settled at capture;
  // a reset here would hand the capture a zero whatever the strap says
  always_ff @(posedge core_clk) begin
    mode_meta <= upgrade_mode_pin;
    mode_sync <= mode_meta;
  end

  // mode captured once after reset release, held until next reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      upgrade_mode <= `UCW_RST_UPGRADE;
      rst_seen     <= `UCW_RST_SEEN;
    end else if (!rst_seen) begin
      upgrade_mode <= mode_sync;
      rst_seen     <= 1'b1;
    end
  end

  // pin and message init look the same downstream
  // while halted a message init is only held, pin init always acts
  // a primary core never holds an init back, it has no wakeup to wait for
  assign soft_init = init_pin_rise
                   | ((msg_kind == UCW_MSG_INIT) & (~halted | ~upgrade_mode));
  // no halted term needed: in upgrade mode armed is only ever set with halted
  // wakeup only when upgrade mode, halted and armed
  assign take_wake = (msg_kind == UCW_MSG_WAKE) & upgrade_mode
                   & wake_armed & rst_seen;

  // halted flag: set by reset, or by init in upgrade mode; cleared by accepted wakeup with no init pending, or freely in primary mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      halted <= `UCW_RST_HALTED;
    end else if (!rst_seen) begin
      halted <= `UCW_RST_HALTED;
    end else if (soft_init) begin
      halted <= upgrade_mode;
    end else if (take_wake) begin
      halted <= init_pending; // pending init re-halts
    end else if (!upgrade_mode) begin
      halted <= 1'b0; // primary core runs freely
    end
  end

  // armed flag: one wakeup per reset or init
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wake_armed <= `UCW_RST_ARMED;
    end else if (soft_init) begin
      wake_armed <= 1'b1;
    end else if (take_wake && !init_pending) begin
      wake_armed <= 1'b0;
    end
  end

  // pending init caught while halted, released by wakeup
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      init_pending <= `UCW_RST_PENDING;
    end else if (msg_kind == UCW_MSG_INIT && halted && upgrade_mode && !init_pin_rise) begin
      init_pending <= 1'b1;
    end else if (take_wake || init_pin_rise) begin
      init_pending <= 1'b0;
    end
  end

  // core reset pulse when an init acts, or a pending one is released
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      core_init_pulse <= `UCW_RST_PULSE;
    end else begin
      core_init_pulse <= soft_init | (take_wake & init_pending);
    end
  end

  assign fetch_enable = ~halted;

  // assertions
  // a wakeup that starts the core: accepted, nothing pending, no init beside it
  sequence s_wake_taken;
    take_wake && !init_pending && !soft_init;
  endsequence

  // a wakeup that releases a held init instead of starting the core
  sequence s_wake_releases;
    take_wake && init_pending;
  endsequence

  property p_halt_after_init;
    @(posedge core_clk) disable iff (sys_rst)
      (soft_init && upgrade_mode) |=> halted && wake_armed;
  endproperty
  a_halt_after_init: assert property (p_halt_after_init)
    else $error("core not halted after init");

  property p_wake_runs;
    @(posedge core_clk) disable iff (sys_rst)
      s_wake_taken |=> !halted && !wake_armed;
  endproperty
  a_wake_runs: assert property (p_wake_runs)
    else $error("accepted wakeup did not release core");

  property p_primary_ignores;
    @(posedge core_clk) disable iff (sys_rst)
      (msg_kind == UCW_MSG_WAKE && !upgrade_mode && !soft_init)
        |=> $stable(wake_armed) && $stable(init_pending);
  endproperty
  a_primary_ignores: assert property (p_primary_ignores)
    else $error("primary core reacted to wakeup");

  property p_pending_latch;
    @(posedge core_clk) disable iff (sys_rst)
      (msg_kind == UCW_MSG_INIT && halted && upgrade_mode && !init_pin_rise)
        |=> init_pending && halted;
  endproperty
  a_pending_latch: assert property (p_pending_latch)
    else $error("init while halted not held");

  property p_no_run_without_wake;
    @(posedge core_clk) disable iff (sys_rst)
      ($fell(halted) && upgrade_mode) |-> $past(take_wake);
  endproperty
  a_no_run_without_wake: assert property (p_no_run_without_wake)
    else $error("upgrade core ran without wakeup");

  property p_mode_held;
    @(posedge core_clk) disable iff (sys_rst)
      $past(rst_seen) |-> $stable(upgrade_mode);
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("mode changed after capture");

  property p_pin_init;
    @(posedge core_clk) disable iff (sys_rst)
      init_pin_rise |=> core_init_pulse && wake_armed && !init_pending;
  endproperty
  a_pin_init: assert property (p_pin_init)
    else $error("pin init not acted on");

  property p_rearm;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(wake_armed) |-> $past(soft_init);
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("wakeup rearmed without init");

  // a released init behaves like a fresh one: halted, rearmed, core pulsed
  property p_wake_releases;
    @(posedge core_clk) disable iff (sys_rst)
      s_wake_releases |=> halted && wake_armed && !init_pending && core_init_pulse;
  endproperty
  a_wake_releases: assert property (p_wake_releases)
    else $error("held init not applied at wakeup");

  // later wakeups leave every flag alone once the core is running
  property p_late_wake_ignored;
    @(posedge core_clk) disable iff (sys_rst)
      (msg_kind == UCW_MSG_WAKE && !wake_armed && !soft_init)
        |=> $stable(halted) && $stable(wake_armed) && $stable(init_pending);
  endproperty
  a_late_wake_ignored: assert property (p_late_wake_ignored)
    else $error("disarmed core reacted to wakeup");

  // a primary core, once its mode is captured, is never halted again
  property p_primary_runs;
    @(posedge core_clk) disable iff (sys_rst)
      (rst_seen && !upgrade_mode && !halted) |=> !halted;
  endproperty
  a_primary_runs: assert property (p_primary_runs)
    else $error("primary core halted");

  // reset leaves the core halted, armed, with nothing pending and no pulse;
  // no disable here, this one must look at the cycle that reset lets go
  property p_reset_values;
    @(posedge core_clk)
      sys_rst |=> halted && wake_armed && !init_pending && !upgrade_mode && !core_init_pulse;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("flags wrong after reset");
endmodule

//--- testbench/ucw_boot_model.sv
`timescale 1ns/10ps
// boot processor side: issues decoded messages, one cycle each
module ucw_boot_model #(
  parameter int INIT_GAP = 20, // short stand-in for the long settle
  parameter int WAKE_GAP = 4   // short stand-in for the wake settle
) (
  // clock
  input  wire logic core_clk,
  // message strobe toward the gate
  output logic      msg_valid,
  output logic      msg_is_init,
  output logic      msg_is_wakeup
);
  // idle at time zero
  initial begin
    msg_valid = 1'b0;
    msg_is_init = 1'b0;
    msg_is_wakeup = 1'b0;
  end
  // one message; kind lines scrambled once idle so stale kinds never look valid
  task automatic send(input logic kind_init, input logic kind_wake);
    @(posedge core_clk);
    msg_valid <= 1'b1;
    msg_is_init <= kind_init;
    msg_is_wakeup <= kind_wake;
    @(posedge core_clk);
    msg_valid <= 1'b0;
    msg_is_init <= ~kind_init;
    msg_is_wakeup <= ~kind_wake;
  endtask
  // wake order: init, settle, then two wakeups each with a settle
  task automatic boot();
    send(1'b1, 1'b0);
    repeat (INIT_GAP) @(posedge core_clk);
    repeat (2) begin
      send(1'b0, 1'b1);
      repeat (WAKE_GAP) @(posedge core_clk);
    end
  endtask
endmodule

//--- testbench/ucw_wakeup_gate_tb.sv
`timescale 1ns/10ps
// self-checking bench for the wake-up gate
module ucw_wakeup_gate_tb;
  logic       core_clk = 1'b0;         // 100 MHz
  logic       sys_rst = 1'b1;          // sync, high
  logic       upgrade_mode_pin = 1'b1; // strap
  logic       init_pin = 1'b0;         // async soft init
  logic       msg_valid;
  logic       msg_is_init;
  logic       msg_is_wakeup;
  logic       halted;
  logic       wake_armed;
  logic       init_pending;
  logic       upgrade_mode;
  logic       fetch_enable;
  logic       core_init_pulse;
  logic [5:0] st;                      // mode,halted,armed,pending,fetch,pulse
  int         failures = 0;
  int         checks_done = 0;
  int         cycles = 0;
  assign st = {upgrade_mode, halted, wake_armed, init_pending, fetch_enable,
               core_init_pulse};
  always #5 core_clk = ~core_clk;
  ucw_wakeup_gate ucw_wakeup_gate_i (.core_clk, .sys_rst, .upgrade_mode_pin,
    .init_pin, .msg_valid, .msg_is_init, .msg_is_wakeup, .halted, .wake_armed,
    .init_pending, .upgrade_mode, .fetch_enable, .core_init_pulse);
  ucw_boot_model #(.INIT_GAP(20), .WAKE_GAP(4)) ucw_boot_model_i (.core_clk,
    .msg_valid, .msg_is_init, .msg_is_wakeup);
  // compare the flag vector under a mask, after the edge has landed
  task automatic chk(input logic [5:0] e, input logic [5:0] m);
    #1;
    checks_done++;
    if ((st & m) !== (e & m)) begin
      failures++;
      $display("[FAIL] %0t flags %b want %b", $time, st, e);
    end
  endtask
  // 12-cycle reset with the strap settled well before release
  task automatic rst(input logic mode);
    @(posedge core_clk);
    upgrade_mode_pin <= mode;
    sys_rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // soft init through the pin; waits a bounded time for the core pulse
  task automatic pin_init();
    @(posedge core_clk);
    init_pin <= 1'b1;
    for (int n = 0; n < 8 && core_init_pulse !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk(6'h39, 6'h3f);
    @(posedge core_clk);
    init_pin <= 1'b0;
  endtask
  // upgrade part: halt, pending init, two wakeups, later wakeup ignored
  task automatic s_steps();
    rst(1'b1);
    chk(6'h38, 6'h3f);
    ucw_boot_model_i.send(1'b1, 1'b0);
    chk(6'h3c, 6'h3f);
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h39, 6'h3f);
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h22, 6'h3f);
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h22, 6'h3f);
  endtask
  // shutdown by init message and by pin, each rearms one wakeup
  task automatic s_shut();
    ucw_boot_model_i.send(1'b1, 1'b0);
    chk(6'h39, 6'h3f);
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h22, 6'h3f);
    pin_init();
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h22, 6'h3f);
    ucw_boot_model_i.boot();
    chk(6'h22, 6'h3f);
  endtask
  // primary part: wakeups discarded, strap ignored after reset
  task automatic s_prim();
    rst(1'b0);
    chk(6'h0a, 6'h3f);
    ucw_boot_model_i.send(1'b0, 1'b1);
    chk(6'h0a, 6'h3f);
    ucw_boot_model_i.send(1'b1, 1'b1);
    chk(6'h0b, 6'h3f);
    @(posedge core_clk);
    upgrade_mode_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    ucw_boot_model_i.send(1'b1, 1'b0);
    chk(6'h0b, 6'h3f);
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard; the whole run needs about a hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    s_steps();
    s_shut();
    s_prim();
    final_report();
  end
endmodule
